// [verilog/serial_port_pkg.sv]
// constants shared by the serial control port configuration registers.
// assumes a single core clock domain; the serial pins arrive unsynchronised.
//
// Functional notes
// - only 16-bit instructions; length bit resets to 1 and host keeps it
// - soft reset bit holds the readback select copies at defaults, config keeps its value; not self-clearing, host writes 0 after
// - bit order 0: MSB first, address decrements; 1: LSB first, increments
// - pin select 0: data pin both ways; 1: reads on separate output pin
// - read-only identification byte at 0x003; writes ignored
// - readback select at 0x004 bit 0: 0 buffer copies, 1 active copies
// - writing 1 to 0x232 bit 0 copies buffers to active; clears itself
package serial_port_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam logic [12:0] CFG_ADDR = 13'h000;
  localparam logic [12:0] ID_ADDR = 13'h003;
  localparam logic [12:0] RBSEL_ADDR = 13'h004;
  localparam logic [12:0] UPDATE_ADDR = 13'h232;

  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int CFG_SDO_BIT = 0;
  localparam int CFG_LSB_BIT = 1;
  localparam int CFG_SRST_BIT = 2;
  localparam int CFG_LONG_BIT = 3;
  localparam logic [3:0] CFG_RESET = 4'h8;
  localparam logic RBSEL_RESET = 1'b0;
  localparam int RBSEL_BIT = 0;
  localparam int UPDATE_BIT = 0;
  localparam logic [7:0] VARIANT_CODE_DEFAULT = 8'hA5; // arbitrary value

  // ------------------------------------------------------------
  // instruction layout and counts
  // ------------------------------------------------------------
  localparam int RW_BIT = 15;
  localparam int LEN_HI = 14;
  localparam int LEN_LO = 13;
  localparam logic [1:0] LEN_STREAM = 2'h3;
  localparam logic [4:0] INSTR_LAST = 5'h0F;
  localparam logic [4:0] BYTE_LAST = 5'h07;

  typedef enum logic [1:0] {IDLE, INSTR, DATA, DONE} port_state_t;

endpackage

// [verilog/pin_sync.sv]
// two-flop synchroniser for a group of asynchronous pin levels.
// assumes only the second stage is read by the logic downstream.
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] stage1_r;

  // first stage feeds the second only, to settle metastability
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stage1_r <= '0;
      pinSync <= '0;
    end else begin
      stage1_r <= pinIn;
      pinSync <= stage1_r;
    end
  end

endmodule

// [verilog/serial_port_config_regs.sv]
// serial control port slave holding the port configuration, identification
// and readback select registers. assumes the serial clock is slow against
// core_clk (at least 4 core cycles per phase) and chip select is active low.
`timescale 1ns/10ps
module serial_port_config_regs
  import serial_port_pkg::*;
#(
  parameter logic [7:0] VARIANT_CODE = VARIANT_CODE_DEFAULT
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic serialClk,
  input wire logic chipSel_n,
  input wire logic sdioIn,
  output logic sdioOut,
  output logic sdioOe,
  output logic serialOutPin,
  output logic separateOutputEnable,
  output logic lsbFirst,
  output logic softResetActive,
  output logic readbackActive
);

  // ------------------------------------------------------------
  // pin synchronisation and edge detection
  // ------------------------------------------------------------
  logic [2:0] pinSync;
  logic sclkPrev_r;

  pin_sync #(.WIDTH(3)) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pinIn({serialClk, ~chipSel_n, sdioIn}),
    .pinSync(pinSync)
  );

  // select enters inverted so the cleared synchroniser reads it as released
  wire sclkS = pinSync[2];
  wire csActive = pinSync[1];
  wire rxBit = pinSync[0];
  wire sclkRise = sclkS & ~sclkPrev_r;
  wire sclkFall = ~sclkS & sclkPrev_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sclkPrev_r <= 1'b0;
    end else begin
      sclkPrev_r <= sclkS;
    end
  end

  // ------------------------------------------------------------
  // state and datapath declarations
  // ------------------------------------------------------------
  port_state_t state_r;
  logic [4:0] bitCnt_r;
  logic [15:0] instr_r;
  logic [12:0] addr_r;
  logic rw_r;
  logic [1:0] len_r;
  logic [1:0] byteCnt_r;
  logic [7:0] rxByte_r;
  logic [7:0] txByte_r;
  logic outBit_r;
  logic [3:0] cfgNib_r;
  logic rbBuf_r;
  logic rbAct_r;

  // bit order steers both the instruction and the data shifters
  wire lsbMode = cfgNib_r[CFG_LSB_BIT];
  wire [15:0] instrNext = lsbMode ? {rxBit, instr_r[15:1]} : {instr_r[14:0], rxBit};
  wire [7:0] rxNext = lsbMode ? {rxBit, rxByte_r[7:1]} : {rxByte_r[6:0], rxBit};
  wire [12:0] addrStep = lsbMode ? addr_r + 13'h0001 : addr_r - 13'h0001;

  // transfer bookkeeping; only the long instruction form is decoded
  wire instrDone = (state_r == INSTR) && sclkRise && (bitCnt_r == INSTR_LAST);
  wire byteDone = (state_r == DATA) && sclkRise && (bitCnt_r == BYTE_LAST);
  wire lastByte = (len_r != LEN_STREAM) && (byteCnt_r == len_r);
  wire wrStrobe = byteDone & ~rw_r;

  // write decode per register
  wire wrCfg = wrStrobe && (addr_r == CFG_ADDR);
  wire wrRbSel = wrStrobe && (addr_r == RBSEL_ADDR);
  wire wrUpdate = wrStrobe && (addr_r == UPDATE_ADDR) && rxNext[UPDATE_BIT];

  // soft reset holds the other registers at default while it stands
  wire regReset = reset | cfgNib_r[CFG_SRST_BIT];

  // ------------------------------------------------------------
  // read data selection
  // ------------------------------------------------------------
  wire [7:0] cfgRead = {cfgNib_r[0], cfgNib_r[1], cfgNib_r[2], cfgNib_r[3], cfgNib_r};
  wire rbRead = rbBuf_r ? rbAct_r : rbBuf_r;
  wire [7:0] rdData = (addr_r == CFG_ADDR) ? cfgRead :
                      (addr_r == ID_ADDR) ? VARIANT_CODE :
                      (addr_r == RBSEL_ADDR) ? {7'h00, rbRead} :
                      8'h00; // update bit always reads 0, unmapped reads 0
  wire [7:0] txSrc = (bitCnt_r == 5'h00) ? rdData : txByte_r;

  // ------------------------------------------------------------
  // transfer sequencer
  // ------------------------------------------------------------
  // chip select release aborts any transfer at once, whatever the count
  always_ff @(posedge core_clk) begin
    if (reset || !csActive) begin
      state_r <= IDLE;
      bitCnt_r <= 5'h00;
      byteCnt_r <= 2'h0;
    end else begin
      unique case (state_r)
        IDLE: begin
          state_r <= INSTR;
          bitCnt_r <= 5'h00;
        end
        INSTR: begin
          if (instrDone) begin
            state_r <= DATA;
            bitCnt_r <= 5'h00;
            byteCnt_r <= 2'h0;
          end else if (sclkRise) begin
            bitCnt_r <= bitCnt_r + 5'h01;
          end
        end
        DATA: begin
          if (byteDone) begin
            bitCnt_r <= 5'h00;
            byteCnt_r <= byteCnt_r + 2'h1;
            if (lastByte) begin
              state_r <= DONE;
            end
          end else if (sclkRise) begin
            bitCnt_r <= bitCnt_r + 5'h01;
          end
        end
        DONE: begin
          state_r <= DONE;
        end
      endcase
    end
  end

  // shifters, instruction fields and address stepping
  always_ff @(posedge core_clk) begin
    if (reset) begin
      instr_r <= 16'h0000;
      rxByte_r <= 8'h00;
      addr_r <= 13'h0000;
      rw_r <= 1'b0;
      len_r <= 2'h0;
    end else begin
      if (state_r == INSTR && sclkRise) begin
        instr_r <= instrNext;
      end
      if (instrDone) begin
        rw_r <= instrNext[RW_BIT];
        len_r <= instrNext[LEN_HI:LEN_LO];
        addr_r <= instrNext[ADDR_W-1:0];
      end
      if (state_r == DATA && sclkRise) begin
        rxByte_r <= rxNext;
      end
      if (byteDone) begin
        addr_r <= addrStep;
      end
    end
  end

  // ------------------------------------------------------------
  // read data driver
  // ------------------------------------------------------------
  // read phase lasts past the final rising edge so the last bit still stands
  wire readPhase = csActive && rw_r && (state_r == DATA || state_r == DONE);

  // bits change on the falling serial edge so they stand at the rising one;
  // the pins are let go at the fall that follows the last byte
  always_ff @(posedge core_clk) begin
    if (reset || !readPhase) begin
      outBit_r <= 1'b0;
      sdioOe <= 1'b0;
      separateOutputEnable <= 1'b0;
    end else if (sclkFall && state_r == DONE) begin
      outBit_r <= 1'b0;
      sdioOe <= 1'b0;
      separateOutputEnable <= 1'b0;
    end else if (sclkFall) begin
      outBit_r <= lsbMode ? txSrc[0] : txSrc[7];
      sdioOe <= ~cfgNib_r[CFG_SDO_BIT];
      separateOutputEnable <= cfgNib_r[CFG_SDO_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      txByte_r <= 8'h00;
    end else if (state_r == DATA && sclkFall) begin
      txByte_r <= lsbMode ? {1'b0, txSrc[7:1]} : {txSrc[6:0], 1'b0};
    end
  end

  assign sdioOut = outBit_r;
  assign serialOutPin = outBit_r;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // config keeps its own value through a soft reset so the host can clear it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfgNib_r <= CFG_RESET;
    end else if (wrCfg) begin
      cfgNib_r <= rxNext[3:0];
    end
  end

  // buffer and active copies; writes to the identification byte fall through
  always_ff @(posedge core_clk) begin
    if (regReset) begin
      rbBuf_r <= RBSEL_RESET;
      rbAct_r <= RBSEL_RESET;
    end else begin
      if (wrRbSel) begin
        rbBuf_r <= rxNext[RBSEL_BIT];
      end
      if (wrUpdate) begin
        rbAct_r <= rbBuf_r;
      end
    end
  end

  // status outputs straight from the holding flops
  assign lsbFirst = cfgNib_r[CFG_LSB_BIT];
  assign softResetActive = cfgNib_r[CFG_SRST_BIT];
  assign readbackActive = rbAct_r;

endmodule

// [bench/serial_port_config_regs_monitor.sv]
// port checker for the serial configuration register block.
// assumes one core clock domain and bind to the design's top module.
`timescale 1ns/10ps
module serial_port_config_regs_monitor (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic serialClk,
  input wire logic chipSel_n,
  input wire logic sdioIn,
  input wire logic sdioOut,
  input wire logic sdioOe,
  input wire logic serialOutPin,
  input wire logic separateOutputEnable,
  input wire logic lsbFirst,
  input wire logic softResetActive,
  input wire logic readbackActive
);
  // ------------------------------------------------------------
  // port relations
  // ------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_oe_exclusive: assert property (!(sdioOe && separateOutputEnable))
    else $error("both read pins driven");
  chk_pins_agree: assert property (sdioOut == serialOutPin)
    else $error("read pins disagree");
  chk_oe_release: assert property (chipSel_n [*6] |-> !sdioOe && !separateOutputEnable)
    else $error("read pin driven without select");
  chk_reset_defaults: assert property ($fell(reset) |-> !lsbFirst
    && !softResetActive && !readbackActive && !sdioOe && !separateOutputEnable)
    else $error("outputs not at defaults after reset");
  chk_srst_holds: assert property (softResetActive [*3] |-> !readbackActive)
    else $error("readback select not held at default");
  chk_cfg_in_frame: assert property
    ($changed({lsbFirst, softResetActive, readbackActive}) |-> !chipSel_n)
    else $error("register changed outside a transfer");
  chk_bit_on_fall: assert property ($changed(sdioOut) |-> !serialClk)
    else $error("read bit moved while serial clock high");
  chk_oe_rise_frame: assert property
    ($rose(sdioOe || separateOutputEnable) |-> !serialClk && !chipSel_n)
    else $error("read pin enabled out of place");
endmodule
bind serial_port_config_regs serial_port_config_regs_monitor mon (.core_clk(core_clk),
  .reset(reset), .serialClk(serialClk), .chipSel_n(chipSel_n), .sdioIn(sdioIn),
  .sdioOut(sdioOut), .sdioOe(sdioOe), .serialOutPin(serialOutPin),
  .separateOutputEnable(separateOutputEnable), .lsbFirst(lsbFirst),
  .softResetActive(softResetActive), .readbackActive(readbackActive));

// [bench/serial_host_model.sv]
// host controller model for the serial control port.
// assumes 80 ns serial clock, driven at core clock falling edges.
`timescale 1ns/10ps
module serial_host_model (
  input wire logic core_clk,
  input wire logic sdioOut,
  input wire logic serialOutPin,
  output logic serialClk,
  output logic chipSel_n,
  output logic hostSdio
);
  logic lsb = 1'b0;
  logic sep = 1'b0;
  initial begin
    serialClk = 1'b0;
    chipSel_n = 1'b1;
    hostSdio = 1'b0;
  end
  task automatic half();
    repeat (5) @(negedge core_clk);
  endtask
  // one frame of 1 or 2 bytes; byte k sits in bits [8k+7:8k] of wd and rd
  task automatic xfer(input logic rw, input logic [12:0] a, input int n,
      input logic [15:0] wd, output logic [15:0] rd);
    logic [15:0] ins;
    int j;
    int k;
    ins = {rw, (n == 2) ? 2'h1 : 2'h0, a};
    rd = 16'h0000;
    chipSel_n <= 1'b0;
    half();
    for (int i = 0; i < 16 + 8 * n; i++) begin
      k = (i < 16) ? 0 : 8 * ((i - 16) / 8);
      j = (i < 16) ? i : (i - 16) % 8;
      if (!lsb) j = ((i < 16) ? 15 : 7) - j;
      // released during read data, so toggle rather than hold a stale level
      hostSdio <= (rw && i >= 16) ? ~hostSdio : ((i < 16) ? ins[j] : wd[k + j]);
      half();
      serialClk <= 1'b1;
      half();
      if (i >= 16) rd[k + j] = sep ? serialOutPin : sdioOut;
      serialClk <= 1'b0;
    end
    half();
    chipSel_n <= 1'b1;
    hostSdio <= ~hostSdio;
    // select must stay high long enough for the port to see the frame end
    half();
  endtask
endmodule

// [bench/serial_port_config_regs_tb.sv]
// self-checking bench for the serial configuration register block.
// assumes the host model performs whole frames; checks follow each read frame and some of the writes.
`timescale 1ns/10ps
module serial_port_config_regs_tb;
  import serial_port_pkg::*;
  localparam logic [7:0] CODE = 8'h3C; // arbitrary value
  logic core_clk, reset, serialClk, chipSel_n, hostSdio, sdioIn, sdioOut, sdioOe;
  logic serialOutPin, separateOutputEnable, lsbFirst, softResetActive, readbackActive;
  logic [15:0] rdata;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // wire level of the shared data pin
  assign sdioIn = sdioOe ? sdioOut : hostSdio;
  // levels the host reads; an undriven pin shows the inverse of the bit
  logic sdioRead, sdoRead;
  assign sdioRead = sdioOe ? sdioOut : ~sdioOut;
  assign sdoRead = separateOutputEnable ? serialOutPin : ~serialOutPin;
  serial_port_config_regs #(.VARIANT_CODE(CODE)) DUT (.core_clk(core_clk), .reset(reset),
    .serialClk(serialClk), .chipSel_n(chipSel_n), .sdioIn(sdioIn), .sdioOut(sdioOut),
    .sdioOe(sdioOe), .serialOutPin(serialOutPin),
    .separateOutputEnable(separateOutputEnable), .lsbFirst(lsbFirst),
    .softResetActive(softResetActive), .readbackActive(readbackActive));
  serial_host_model host (.core_clk(core_clk), .sdioOut(sdioRead),
    .serialOutPin(sdoRead), .serialClk(serialClk), .chipSel_n(chipSel_n),
    .hostSdio(hostSdio));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, 1, {8'h00, d}, rdata);
  endtask
  task automatic rd(input logic [12:0] a, input int n, input logic [15:0] exp);
    host.xfer(1'b1, a, n, 16'h0000, rdata);
    chk(rdata, exp);
  endtask
  task automatic finish_test();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hang guard, about four times the expected run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    reset <= 1'b0;
    repeat (4) @(negedge core_clk);
    rd(CFG_ADDR, 1, 16'h0018);
    wr(ID_ADDR, 8'hFF);
    rd(ID_ADDR, 1, {8'h00, CODE});
    wr(RBSEL_ADDR, 8'h01);
    chk({15'h0, readbackActive}, 16'h0000);
    rd(RBSEL_ADDR, 1, 16'h0000);
    wr(UPDATE_ADDR, 8'h01);
    chk({15'h0, readbackActive}, 16'h0001);
    rd(UPDATE_ADDR, 1, 16'h0000);
    rd(RBSEL_ADDR, 2, {CODE, 8'h01});
    wr(CFG_ADDR, 8'h5A);
    host.lsb = 1'b1;
    chk({15'h0, lsbFirst}, 16'h0001);
    rd(ID_ADDR, 2, {8'h01, CODE});
    wr(CFG_ADDR, 8'hDB);
    host.sep = 1'b1;
    rd(CFG_ADDR, 1, 16'h00DB);
    wr(CFG_ADDR, 8'h18);
    host.lsb = 1'b0;
    host.sep = 1'b0;
    wr(CFG_ADDR, 8'h3C);
    chk({15'h0, softResetActive}, 16'h0001);
    wr(RBSEL_ADDR, 8'h01);
    wr(UPDATE_ADDR, 8'h01);
    chk({15'h0, readbackActive}, 16'h0000);
    rd(RBSEL_ADDR, 1, 16'h0000);
    wr(CFG_ADDR, 8'h18);
    chk({15'h0, softResetActive}, 16'h0000);
    rd(CFG_ADDR, 1, 16'h0018);
    finish_test();
  end
endmodule
